// >>> spitx_defines.svh
// Purpose: Offsets, field positions, resets, counts
// Assumes: Word-aligned classic Wishbone slave
// Notes:   Definitions only
`ifndef SPITX_DEFINES_SVH
`define SPITX_DEFINES_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SPITX_OFS_PLAIN 8'h00
`define SPITX_OFS_CTRL  8'h04
`define SPITX_OFS_GCR   8'h08
`define SPITX_OFS_DEF   8'h0c
`define SPITX_OFS_FMT0  8'h10
`define SPITX_OFS_FMT3  8'h1c
`define SPITX_OFS_STAT  8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPITX_HOLD_BIT  28
`define SPITX_DELAY_BIT 26
`define SPITX_FSEL_LSB  24
`define SPITX_PAT_LSB   16
`define SPITX_EN_BIT    0
`define SPITX_MST_BIT   1
`define SPITX_T2C_LSB   8
`define SPITX_LEN_LSB   16
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SPITX_RST_WORD  32'h0000_0000
`define SPITX_MIN_GAP   9'h002
`define SPITX_HALF_BIT  8'h04
`define SPITX_FIFO_DEP  16
`endif

// >>> spitx_pkg.sv
// Purpose: Shared types of the transmit front end
// Assumes: Included header gives the constants
// Notes:   Types only
package spitx_pkg;
	// One queued transfer
	typedef struct packed {
		logic [15:0] word;
		logic [7:0]  pattern;
		logic        hold;
		logic        delay;
		logic [1:0]  fsel;
	} spitx_entry_s;
	// One data format register
	typedef struct packed {
		logic [4:0] len;
		logic [7:0] t2c;
		logic [7:0] wdly;
	} spitx_fmt_s;
	// Transfer sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SHIFT = 3'b001,
		ST_T2C   = 3'b010,
		ST_GAP   = 3'b011,
		ST_HOLD  = 3'b100
	} spitx_state_e;
endpackage

// >>> spitx_top.sv
// Purpose: Transmit data and control front end
// Assumes: 250 MHz clk_i, sync active-high rst_i
// Notes:   Classic Wishbone slave, 16-word queue
//
// Summary of operation
// - Word enters queue, then holding buffer, then shifter
// - Enable cleared zeroes both data fields
// - Plain writes use selected format, default 0
// - Reserved bits read zero, ignore writes
// - Select hold acts in master only
// - Hold clear: release select after delay
// - Hold set: select stays until new data
// - Delay enable acts in master only
// - No delay: select off at least three cycles
// - Delay: gap of wait delay plus three
// - Format select picks one of four
// - Control-only byte write starts nothing
// - Pattern bits drive select pins directly
// - Idle select pins show default levels
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spitx_defines.svh"

// ----------------------------------------
// Parameterised queue
// ----------------------------------------
module spitx_fifo #(
	parameter int W = 28,
	parameter int D = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	// Whole queue state
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       rd;
		logic [AW-1:0]       wr;
		logic [AW:0]         cnt;
	} spitx_fq_s;
	spitx_fq_s s;
	spitx_fq_s next_s;
	logic      push;
	logic      pop;
	// Handshakes
	assign in_ready_o  = (s.cnt != (AW+1)'(D));
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o  = s.mem[s.rd];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	// Next state
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data_i;
			next_s.wr = s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = s.rd + 1'b1;
		end
		next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (flush_i) begin
			next_s.rd  = '0;
			next_s.wr  = '0;
			next_s.cnt = '0;
		end
	end
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ----------------------------------------
// Front end top
// ----------------------------------------
module spitx_top
	import spitx_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	input  wire logic        serial_clock_i,
	output logic             serial_clock_o,
	output logic             serial_clock_oe_o,
	output logic             data_out_o,
	output logic [7:0]       chip_select_pin_o,
	output logic [7:0]       chip_select_oe_o
);
	// Whole block state
	typedef struct packed {
		logic                  ack;
		logic [31:0]           rdat;
		logic                  enable;
		logic                  master;
		logic [7:0]            def_lvls;
		logic [3:0][20:0]      fmts;
		logic                  hold;
		logic                  delay;
		logic [1:0]            fsel;
		logic [7:0]            pattern;
		logic [15:0]           plain_word;
		logic [15:0]           ctrl_word;
		logic                  buf_full;
		spitx_entry_s          hbuf;
		spitx_entry_s          cur;
		logic [15:0]           sh;
		spitx_state_e          st;
		logic [8:0]            cnt;
		logic [4:0]            bits;
		logic                  sclk;
		logic                  dout;
		logic [7:0]            cs;
		logic                  lk1;
		logic                  lk2;
		logic                  lk3;
	} spitx_top_s;
	spitx_top_s   s;
	spitx_top_s   next_s;
	// Bus and queue wires
	logic         req;
	logic         dwr;
	logic         q_ready;
	logic         q_valid;
	logic         q_out_valid;
	logic         q_take;
	spitx_entry_s q_in;
	spitx_entry_s q_out;
	spitx_fmt_s   f;
	logic [15:0]  merged;
	logic         lk_rise;

	// Byte-lane merge of a data half
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_v,
		input logic [31:0] wd,
		input logic [3:0]  sel
	);
		lane_merge = {sel[1] ? wd[15:8] : old_v[15:8],
			sel[0] ? wd[7:0] : old_v[7:0]};
	endfunction

	// Character length, zero meaning sixteen
	function automatic logic [4:0] char_len(input spitx_fmt_s fm);
		char_len = (fm.len == 5'h00 || fm.len > 5'h10) ? 5'h10 : fm.len;
	endfunction

	// ----------------------------------------
	// Bus decode and queue feed
	// ----------------------------------------
	assign req = cyc_i & stb_i & ~s.ack;
	// Data half touched on a data register
	assign dwr = req & we_i & (sel_i[1] | sel_i[0]) &
		(adr_i == `SPITX_OFS_PLAIN || adr_i == `SPITX_OFS_CTRL);
	assign q_valid = dwr & s.enable;
	// Merged data for whichever register
	assign merged = (adr_i == `SPITX_OFS_PLAIN) ?
		lane_merge(s.plain_word, dat_i, sel_i) :
		lane_merge(s.ctrl_word, dat_i, sel_i);
	// Entry carries control after this write
	always_comb begin
		q_in.word    = merged;
		q_in.hold    = s.hold;
		q_in.delay   = s.delay;
		q_in.fsel    = s.fsel;
		q_in.pattern = s.pattern;
		if (adr_i == `SPITX_OFS_CTRL) begin
			if (sel_i[3]) begin
				q_in.hold  = dat_i[`SPITX_HOLD_BIT];
				q_in.delay = dat_i[`SPITX_DELAY_BIT];
				q_in.fsel  = dat_i[`SPITX_FSEL_LSB +: 2];
			end
			if (sel_i[2]) begin
				q_in.pattern = dat_i[`SPITX_PAT_LSB +: 8];
			end
		end
	end

	// Queue in front of the holding buffer
	spitx_fifo #(
		.W ($bits(spitx_entry_s)),
		.D (`SPITX_FIFO_DEP)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (~s.enable),
		.in_valid_i  (q_valid),
		.in_ready_o  (q_ready),
		.in_data_i   (q_in),
		.out_valid_o (q_out_valid),
		.out_ready_i (~s.buf_full & s.enable),
		.out_data_o  (q_out)
	);
	assign q_take = q_out_valid & ~s.buf_full & s.enable;
	// Format of the active transfer
	assign f = s.fmts[s.cur.fsel];
	// Rising edge of the synchronised link clock
	assign lk_rise = s.lk2 & ~s.lk3;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s     = s;
		next_s.ack = 1'b0;
		// Link clock synchroniser
		next_s.lk1 = serial_clock_i;
		next_s.lk2 = s.lk1;
		next_s.lk3 = s.lk2;
		// Bus access; data writes wait for room
		if (req && (!q_valid || q_ready)) begin
			next_s.ack  = 1'b1;
			next_s.rdat = '0;
			if (we_i) begin
				case (adr_i)
					`SPITX_OFS_PLAIN: begin
						next_s.plain_word = merged;
					end
					`SPITX_OFS_CTRL: begin
						next_s.ctrl_word = merged;
						next_s.hold      = q_in.hold;
						next_s.delay     = q_in.delay;
						next_s.fsel      = q_in.fsel;
						next_s.pattern   = q_in.pattern;
					end
					`SPITX_OFS_GCR: begin
						if (sel_i[0]) begin
							next_s.enable = dat_i[`SPITX_EN_BIT];
							next_s.master = dat_i[`SPITX_MST_BIT];
						end
					end
					`SPITX_OFS_DEF: begin
						if (sel_i[0]) begin
							next_s.def_lvls = dat_i[7:0];
						end
					end
					default: begin
						// Format registers, rest ignored
						if (adr_i >= `SPITX_OFS_FMT0 &&
							adr_i <= `SPITX_OFS_FMT3) begin
							next_s.fmts[adr_i[3:2]] = dat_i[20:0];
						end
					end
				endcase
			end else begin
				case (adr_i)
					`SPITX_OFS_PLAIN: begin
						next_s.rdat = {16'h0000, s.plain_word};
					end
					`SPITX_OFS_CTRL: begin
						next_s.rdat = {3'h0, s.hold, 1'b0, s.delay,
							s.fsel, s.pattern, s.ctrl_word};
					end
					`SPITX_OFS_GCR: begin
						next_s.rdat = {30'h0, s.master, s.enable};
					end
					`SPITX_OFS_DEF: begin
						next_s.rdat = {24'h0, s.def_lvls};
					end
					`SPITX_OFS_STAT: begin
						next_s.rdat = {27'h0, s.st, s.buf_full, q_out_valid};
					end
					default: begin
						if (adr_i >= `SPITX_OFS_FMT0 &&
							adr_i <= `SPITX_OFS_FMT3) begin
							next_s.rdat = {11'h0, s.fmts[adr_i[3:2]]};
						end
					end
				endcase
			end
		end
		// Queue head into holding buffer
		if (q_take) begin
			next_s.hbuf     = q_out;
			next_s.buf_full = 1'b1;
		end
		// Transfer sequencer
		case (s.st)
			ST_IDLE, ST_HOLD: begin
				// Shifter empty: take buffered word at once
				if (s.buf_full) begin
					next_s.buf_full = 1'b0;
					next_s.cur      = s.hbuf;
					next_s.sh       = s.hbuf.word <<
						(5'h10 - char_len(s.fmts[s.hbuf.fsel]));
					next_s.bits     = char_len(s.fmts[s.hbuf.fsel]);
					next_s.cnt      = {1'b0, `SPITX_HALF_BIT};
					next_s.sclk     = 1'b0;
					next_s.st       = ST_SHIFT;
					next_s.cs       = s.hbuf.pattern;
				end else if (s.st == ST_IDLE) begin
					next_s.cs = s.def_lvls;
				end
			end
			ST_SHIFT: begin
				next_s.dout = s.sh[15];
				if (s.master) begin
					// Own serial clock from a divider
					if (s.cnt == 9'h000) begin
						next_s.cnt  = {1'b0, `SPITX_HALF_BIT};
						next_s.sclk = ~s.sclk;
						if (s.sclk) begin
							next_s.sh   = {s.sh[14:0], 1'b0};
							next_s.bits = s.bits - 5'h01;
						end
					end else begin
						next_s.cnt = s.cnt - 9'h001;
					end
				end else if (lk_rise) begin
					// Partner clock paces the shifter
					next_s.sh   = {s.sh[14:0], 1'b0};
					next_s.bits = s.bits - 5'h01;
				end
				// Last bit done
				if (s.bits == 5'h00) begin
					next_s.sclk = 1'b0;
					if (!s.master) begin
						next_s.st = ST_IDLE;
					end else if (s.cur.hold) begin
						next_s.st = ST_HOLD;
					end else begin
						next_s.st  = ST_T2C;
						next_s.cnt = {1'b0, f.t2c};
					end
				end
			end
			ST_T2C: begin
				// Select stays until end delay passes
				if (s.cnt == 9'h000) begin
					next_s.st  = ST_GAP;
					next_s.cs  = s.def_lvls;
					next_s.cnt = s.cur.delay ?
						({1'b0, f.wdly} + `SPITX_MIN_GAP - 9'h001) :
						(`SPITX_MIN_GAP - 9'h001);
				end else begin
					next_s.cnt = s.cnt - 9'h001;
				end
			end
			ST_GAP: begin
				// Select released, no new start yet
				if (s.cnt == 9'h000) begin
					next_s.st = ST_IDLE;
				end else begin
					next_s.cnt = s.cnt - 9'h001;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		// Disabled: clear data fields and traffic
		if (!s.enable) begin
			next_s.plain_word = '0;
			next_s.ctrl_word  = '0;
			next_s.buf_full   = 1'b0;
			next_s.st         = ST_IDLE;
			next_s.sclk       = 1'b0;
			next_s.cs         = s.def_lvls;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s    <= '0;
			s.st <= ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs, all from flops
	// ----------------------------------------
	assign ack_o             = s.ack;
	assign dat_o             = s.rdat;
	assign serial_clock_o    = s.sclk;
	assign serial_clock_oe_o = s.master;
	assign data_out_o        = s.dout;
	assign chip_select_pin_o = s.cs;
	assign chip_select_oe_o  = {8{s.master}};
endmodule
`default_nettype wire

// >>> spitx_top_props.sv
// Purpose: Port checks of spitx_top
// Assumes: Single domain clk_i, reset rst_i
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
// ----
// Checker
// ----
module spitx_top_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        serial_clock_o,
	input wire logic        serial_clock_oe_o,
	input wire logic        data_out_o,
	input wire logic [7:0]  chip_select_pin_o,
	input wire logic [7:0]  chip_select_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_plain_resv: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h00
		|-> dat_o[31:16] == 16'h0000) else $error("plain upper half not zero");
	a_ctrl_resv: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h04
		|-> dat_o[31:29] == 3'h0 && !dat_o[27]) else $error("control reserved bits set");
	a_mode_oe: assert property (serial_clock_oe_o == (chip_select_oe_o == 8'hff))
		else $error("enables disagree on mode");
	a_clk_idle: assert property (!serial_clock_oe_o |-> !serial_clock_o)
		else $error("clock moves outside master mode");
	a_half_bit: assert property ($rose(serial_clock_o) |-> serial_clock_o[*5] ##1 !serial_clock_o)
		else $error("clock high phase wrong");
	a_cs_steady: assert property (serial_clock_o |-> $stable(chip_select_pin_o))
		else $error("select moved during bit");
	a_data_steady: assert property (serial_clock_o && $past(serial_clock_o) |-> $stable(data_out_o))
		else $error("data moved while clock high");
	a_low_gap: assert property ($fell(serial_clock_o) |-> !serial_clock_o[*4])
		else $error("clock low phase short");
endmodule
`default_nettype wire

// >>> spitx_partner.sv
// Purpose: Serial slave model on select pin 0
// Assumes: Mode 0, MSB first, select low active
// Notes:   Also makes the 125 ns slave-mode clock
`timescale 1ns/1ps
`default_nettype none
module spitx_partner (
	input  wire logic   sclk_i,
	input  wire logic   mosi_i,
	input  wire logic   sel_n_i,
	input  wire logic   run_i,
	output logic        sclk_o,
	output logic [15:0] word_o,
	output logic [7:0]  frames_o
);
	logic [7:0] nbits; // Bits seen so far
	logic [7:0] last;  // Bit count at last release
	initial begin
		sclk_o = 1'b0;
		word_o = 16'h0000;
		frames_o = 8'h00;
		nbits = 8'h00;
		last = 8'h00;
	end
	// Sample on rising clock while selected
	always @(posedge sclk_i) if (!sel_n_i) begin
		word_o <= {word_o[14:0], mosi_i};
		nbits <= nbits + 8'h01;
	end
	// A release after bits closes one frame
	always @(posedge sel_n_i) begin
		if (nbits != last) frames_o <= frames_o + 8'h01;
		last <= nbits;
	end
	// Link clock only while run_i is high
	always #62.5 sclk_o <= run_i ? ~sclk_o : 1'b0;
endmodule
`default_nettype wire

// >>> spitx_top_tb_top.sv
// Purpose: Self-checking bench of spitx_top
// Assumes: Partner slave on select pin 0
// Notes:   Directed tests over shared bus tasks
`timescale 1ns/1ps
`default_nettype none
module spitx_top_tb_top;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, run;
	logic [7:0]  adr_i, cs, cs_oe, frames;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic        ack_o, sck_in, sck, sck_oe, dout;
	logic [15:0] word;
	int          n_fail, samples_checked, g;
	spitx_top spitx_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .serial_clock_i(sck_in),
		.serial_clock_o(sck), .serial_clock_oe_o(sck_oe), .data_out_o(dout), .chip_select_pin_o(cs),
		.chip_select_oe_o(cs_oe));
	spitx_partner spitx_partner_inst (.sclk_i(sck), .mosi_i(dout), .sel_n_i(cs[0]), .run_i(run),
		.sclk_o(sck_in), .word_o(word), .frames_o(frames));
	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Compare and count
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// One classic Wishbone cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 300);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			check("bus ack", 32'h0, 32'h1);
			finish_test;
		end
	endtask
	// Bounded wait for a frame count
	task wait_frames(input logic [7:0] n);
		for (int i = 0; i < 3000 && frames !== n; i++) @(posedge clk_i);
		if (frames !== n) begin
			check("frame wait", {24'h0, frames}, {24'h0, n});
			finish_test;
		end
	endtask
	task t_reset;
		wb(1'b0, 8'h00, 32'h0, 4'hf);
		check("plain reset", rd, 32'h0);
		wb(1'b0, 8'h04, 32'h0, 4'hf);
		check("ctrl reset", rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0, 4'hf);
		check("unmapped", rd, 32'h0);
		$display("test reset done");
	endtask
	task t_basic;
		wb(1'b1, 8'h08, 32'h3, 4'hf);
		wb(1'b1, 8'h0c, 32'hff, 4'hf);
		wb(1'b1, 8'h10, 32'h0008_0100, 4'hf);
		wb(1'b1, 8'h14, 32'h0010_0003, 4'hf);
		wb(1'b1, 8'h1c, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h1c, 32'h0, 4'hf);
		check("fmt3 read", rd, 32'h001f_ffff);
		wb(1'b1, 8'h04, 32'he0fe_80a5, 4'hf);
		wb(1'b0, 8'h04, 32'h0, 4'hf);
		check("ctrl read", rd, 32'h00fe_80a5);
		check("oe", {16'h0, cs_oe, 7'h0, sck_oe}, 32'h0000_ff01);
		wait_frames(8'h01);
		check("byte", {24'h0, word[7:0]}, 32'ha5);
		check("idle cs", {24'h0, cs}, 32'hff);
		$display("test basic done");
	endtask
	task t_queue;
		wb(1'b1, 8'h00, 32'h11, 4'hf);
		wb(1'b1, 8'h00, 32'h22, 4'hf);
		wb(1'b1, 8'h00, 32'h33, 4'hf);
		wait_frames(8'h02);
		g = 0;
		while (cs[0] === 1'b1 && g < 500) begin
			@(posedge clk_i);
			g++;
		end
		check("short gap", {31'h0, g >= 2 && g < 500}, 32'h1);
		wait_frames(8'h04);
		check("queued", {16'h0, word}, 32'h2233);
		$display("test queue done");
	endtask
	task t_presel;
		wb(1'b1, 8'h04, 32'h0100_0000, 4'h8);
		repeat (200) @(posedge clk_i);
		check("no start", {24'h0, frames}, 32'h4);
		wb(1'b1, 8'h00, 32'h0000_beef, 4'h3);
		wait_frames(8'h05);
		check("format one", {16'h0, word}, 32'hbeef);
		$display("test preselect done");
	endtask
	task t_hold;
		wb(1'b1, 8'h04, 32'h10fe_0055, 4'hf);
		repeat (250) @(posedge clk_i);
		check("held cs", {24'h0, cs}, 32'hfe);
		check("held frame", {24'h0, frames}, 32'h5);
		wb(1'b1, 8'h04, 32'h00fe_0066, 4'hf);
		wait_frames(8'h06);
		check("joined", {16'h0, word}, 32'h5566);
		$display("test hold done");
	endtask
	task t_delay;
		wb(1'b1, 8'h04, 32'h05fe_1234, 4'hf);
		wb(1'b1, 8'h00, 32'h5678, 4'hf);
		wait_frames(8'h07);
		g = 0;
		while (cs[0] === 1'b1 && g < 500) begin
			@(posedge clk_i);
			g++;
		end
		check("gap", {31'h0, g >= 5 && g < 500}, 32'h1);
		wait_frames(8'h08);
		check("second", {16'h0, word}, 32'h5678);
		$display("test delay done");
	endtask
	task t_disable;
		wb(1'b1, 8'h08, 32'h2, 4'hf);
		wb(1'b0, 8'h00, 32'h0, 4'hf);
		check("plain clr", {16'h0, rd[15:0]}, 32'h0);
		wb(1'b0, 8'h04, 32'h0, 4'hf);
		check("ctrl clr", {16'h0, rd[15:0]}, 32'h0);
		$display("test disable done");
	endtask
	task t_slave;
		wb(1'b1, 8'h08, 32'h1, 4'hf);
		wb(1'b1, 8'h04, 32'h1400_0077, 4'hf);
		wb(1'b0, 8'h20, 32'h0, 4'hf);
		check("slave wait", rd, 32'h4);
		run <= 1'b1;
		repeat (1000) @(posedge clk_i);
		run <= 1'b0;
		check("slave oe", {23'h0, cs_oe, sck_oe}, 32'h0);
		wb(1'b0, 8'h20, 32'h0, 4'hf);
		check("slave done", rd, 32'h0);
		$display("test slave done");
	endtask
	// Main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i, run} = 5'b10000;
		{adr_i, sel_i, dat_i} = '0;
		n_fail = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_basic;
		t_queue;
		t_presel;
		t_hold;
		t_delay;
		t_disable;
		t_slave;
		finish_test;
	end
endmodule
bind spitx_top spitx_top_props spitx_top_props_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .serial_clock_o(serial_clock_o),
	.serial_clock_oe_o(serial_clock_oe_o), .data_out_o(data_out_o), .chip_select_pin_o(chip_select_pin_o),
	.chip_select_oe_o(chip_select_oe_o));
`default_nettype wire
